// File: include/wer_pkg.sv
// shared constants of the wake-up event routing block
package wer_pkg;

	// ==========================================================
	// register offsets within every bank
	localparam logic [7:0] WER_OFS_EVENT_SELECT = 8'h00;
	localparam logic [7:0] WER_OFS_STATE_ENABLE = 8'h01;
	localparam logic [7:0] WER_OFS_IRQ_EN_LOW   = 8'h02;

	// ==========================================================
	// widths and counts
	localparam int unsigned WER_REG_W      = 8;
	localparam int unsigned WER_ADDR_W     = 8;
	localparam int unsigned WER_SEL_W      = 5;
	localparam int unsigned WER_NUM_EVENTS = 32;
	localparam int unsigned WER_CFG_W      = 4;
	localparam int unsigned WER_IRQ_LOW_N  = 8;
	localparam int unsigned WER_IRQ_BASE   = 16;

	// ==========================================================
	// per-event wake state field positions
	localparam int unsigned WER_BIT_ON_SOFT_OFF     = 0;
	localparam int unsigned WER_BIT_ON_SUSPEND_RAM  = 1;
	localparam int unsigned WER_BIT_PULSE_SOFT_OFF  = 2;
	localparam int unsigned WER_BIT_PULSE_SUSP_RAM  = 3;

	// ==========================================================
	// event classes: class b keeps only the two power-on enables
	localparam logic [WER_CFG_W-1:0]      WER_MASK_CLASS_A  = 4'hf;
	localparam logic [WER_CFG_W-1:0]      WER_MASK_CLASS_B  = 4'h3;
	localparam logic [WER_CFG_W-1:0]      WER_MASK_NONE     = 4'h0;
	localparam logic [WER_NUM_EVENTS-1:0] WER_EVENTS_CLASS_B = 32'h0e00_0000;
	localparam logic [WER_NUM_EVENTS-1:0] WER_EVENTS_UNUSED  = 32'h2080_0000;

	// ==========================================================
	// reset values
	localparam logic [WER_SEL_W-1:0]     WER_RST_EVENT_SELECT = 5'h00;
	localparam logic [WER_CFG_W-1:0]     WER_RST_STATE_ENABLE = 4'h0;
	localparam logic [WER_IRQ_LOW_N-1:0] WER_RST_IRQ_EN_LOW   = 8'h00;

	// ==========================================================
	// timing: power-button pulse length at the 50 mhz core clock
	localparam int unsigned WER_CLK_MHZ       = 50;
	localparam int unsigned WER_PULSE_TIME_US = 200;
	localparam int unsigned WER_PULSE_CYCLES  = WER_PULSE_TIME_US * WER_CLK_MHZ;

endpackage

// File: include/wer_mem_if.sv
// link between the routing logic and its per-event configuration store
`timescale 1ns/1ps
interface wer_mem_if;
	import wer_pkg::*;

	logic                                      wrEn;
	logic [WER_SEL_W-1:0]                      wrIdx;
	logic [WER_CFG_W-1:0]                      wrData;
	logic [WER_SEL_W-1:0]                      rdIdx;
	logic [WER_CFG_W-1:0]                      rdData;
	logic [WER_NUM_EVENTS-1:0][WER_CFG_W-1:0] entries;

	modport ctrl (output wrEn, output wrIdx, output wrData, output rdIdx,
		input rdData, input entries);
	modport mem  (input wrEn, input wrIdx, input wrData, input rdIdx,
		output rdData, output entries);
endinterface

// File: logic/wer_state_mem.sv
// per-event wake state store with a registered read port
`timescale 1ns/1ps
module wer_state_mem
	import wer_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// routing side
	wer_mem_if.mem   port
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [WER_NUM_EVENTS-1:0][WER_CFG_W-1:0] entry;
		logic [WER_CFG_W-1:0]                      rd;
	} wer_mem_state_t;

	wer_mem_state_t memQ;
	wer_mem_state_t memD;

	// read sees the value before a same-cycle write
	always_comb begin
		memD = memQ;
		if (port.wrEn) begin
			memD.entry[port.wrIdx] = port.wrData;
		end
		memD.rd = memQ.entry[port.rdIdx];
	end

	// every entry starts disabled
	always_ff @(posedge core_clk) begin
		if (reset) begin
			memQ <= '0;
		end else begin
			memQ <= memD;
		end
	end

	// all entries are visible at once for the event comparators
	assign port.rdData  = memQ.rd;
	assign port.entries = memQ.entry;

endmodule

// File: logic/wer_routing.sv
// wake-up event routing: power-button pulse, main power-on and low irq gating
//
// Operation
// - pulse button output on event in suspend-ram
// - pulse button output on event in soft-off
// - button pulse only while button mode is 0
// - actions ignore the event's own enable bit
// - power-on control on event in suspend-ram
// - power-on control on event in soft-off
// - power-on only when external select is 0
// - all wake state enables reset to disabled
// - low irq enable gates status 16-23, reset 00h
// - bit 7 routes power button to irq
// - bit 6 routes sleep button to irq
// - bit 5 routes pm key 3 to irq
// - bit 4 routes pm key 2 to irq
// - bit 3 routes any key to irq
// - bit 2 routes mouse wake to irq
// - bit 1 routes ring port 2 to irq
// - bit 0 routes ring port 1 to irq
// - wake state register follows event select index
// - class b keeps only power-on enables
`timescale 1ns/1ps
module wer_routing
	import wer_pkg::*;
#(
	parameter int unsigned PULSE_CYCLES = WER_PULSE_CYCLES
) (
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      reset,
	// register port
	input  wire logic [WER_ADDR_W-1:0]     regAddr,
	input  wire logic                      regWrite,
	input  wire logic                      regRead,
	input  wire logic [WER_REG_W-1:0]      regWdata,
	output logic      [WER_REG_W-1:0]      regRdata,
	output logic                           regReadValid,
	// wake event status and device state
	input  wire logic [WER_NUM_EVENTS-1:0] wakeStatus,
	input  wire logic                      inSuspendRam,
	input  wire logic                      inSoftOff,
	// loose configuration bits
	input  wire logic                      buttonOutMode,
	input  wire logic                      externalStateSelect,
	// outputs to platform
	output logic                           powerButtonOut,
	output logic                           mainPowerOnControl,
	output logic                           irq
);

	// ==========================================================
	// elaboration checks
	localparam int unsigned CNT_W = $clog2(PULSE_CYCLES + 1);

	generate
		if (PULSE_CYCLES < 1) begin : g_bad_pulse
			$error("PULSE_CYCLES must be at least one");
		end
		if (WER_NUM_EVENTS != (1 << WER_SEL_W)) begin : g_bad_sel
			$error("event select width does not cover the event count");
		end
	endgenerate

	localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYCLES);
	localparam logic [CNT_W-1:0] CNT_ONE    = CNT_W'(1);

	// ==========================================================
	// state of the block in one record
	typedef struct packed {
		logic [WER_SEL_W-1:0]      sel;
		logic [WER_IRQ_LOW_N-1:0]  irqEn;
		logic [WER_NUM_EVENTS-1:0] prevStatus;
		logic [CNT_W-1:0]          pulseCnt;
		logic                      pulseOut;
		logic                      main_power_on_control;
		logic                      irq;
		logic [WER_REG_W-1:0]      rdata;
		logic                      rvalid;
	} wer_state_t;

	wer_state_t stateQ;
	wer_state_t stateD;

	// ==========================================================
	// configuration store
	wer_mem_if memBus ();

	wer_state_mem u_state_mem (
		.core_clk (core_clk),
		.reset    (reset),
		.port     (memBus.mem)
	);

	// ==========================================================
	// address decode
	logic selWrite;
	logic stateWrite;
	logic irqWrite;
	logic [WER_CFG_W-1:0] classMask;

	assign selWrite   = regWrite && (regAddr == WER_OFS_EVENT_SELECT);
	assign stateWrite = regWrite && (regAddr == WER_OFS_STATE_ENABLE);
	assign irqWrite   = regWrite && (regAddr == WER_OFS_IRQ_EN_LOW);

	// writable bits of the selected event; unused entries hold nothing
	always_comb begin
		if (WER_EVENTS_UNUSED[stateQ.sel]) begin
			classMask = WER_MASK_NONE;
		end else if (WER_EVENTS_CLASS_B[stateQ.sel]) begin
			classMask = WER_MASK_CLASS_B;
		end else begin
			classMask = WER_MASK_CLASS_A;
		end
	end

	// the wake state port always addresses the selected event
	assign memBus.wrEn   = stateWrite;
	assign memBus.wrIdx  = stateQ.sel;
	assign memBus.wrData = regWdata[WER_CFG_W-1:0] & classMask;
	assign memBus.rdIdx  = stateQ.sel;

	// ==========================================================
	// per-event comparators
	logic [WER_NUM_EVENTS-1:0] riseEvt;
	logic [WER_NUM_EVENTS-1:0] pulseHit;
	logic [WER_NUM_EVENTS-1:0] onHit;

	// an event counts once, on the cycle its status bit rises;
	// the event's own general-purpose enable is not consulted
	generate
		for (genvar i = 0; i < WER_NUM_EVENTS; i++) begin : g_evt
			logic [WER_CFG_W-1:0] cfg;
			assign cfg        = memBus.entries[i];
			assign riseEvt[i] = wakeStatus[i] & ~stateQ.prevStatus[i];
			assign pulseHit[i] = riseEvt[i]
				& ((inSuspendRam & cfg[WER_BIT_PULSE_SUSP_RAM])
				| (inSoftOff & cfg[WER_BIT_PULSE_SOFT_OFF]));
			assign onHit[i] = riseEvt[i]
				& ((inSuspendRam & cfg[WER_BIT_ON_SUSPEND_RAM])
				| (inSoftOff & cfg[WER_BIT_ON_SOFT_OFF]));
		end
	endgenerate

	// ==========================================================
	// low irq gating, one enable bit per status bit 16-23
	logic [WER_IRQ_LOW_N-1:0] irqHit;

	// bit n of the enable pairs with status bit 16+n:
	// 7 power button, 6 sleep button, 5 pm key 3, 4 pm key 2,
	// 3 any key, 2 mouse, 1 ring port 2, 0 ring port 1
	generate
		for (genvar j = 0; j < WER_IRQ_LOW_N; j++) begin : g_irq
			assign irqHit[j] = wakeStatus[WER_IRQ_BASE + j] & stateQ.irqEn[j];
		end
	endgenerate

	// ==========================================================
	// combined triggers
	logic pulseTrigger;
	logic onTrigger;
	logic awake;

	// the pulse path is shut while the output pin runs in its other mode
	assign pulseTrigger = (|pulseHit) & ~buttonOutMode;
	// power-on is left to an external controller when it is selected
	assign onTrigger    = (|onHit) & ~externalStateSelect;
	assign awake        = ~inSuspendRam & ~inSoftOff;

	// ==========================================================
	// next state
	always_comb begin
		stateD = stateQ;
		stateD.rvalid = 1'b0;
		stateD.prevStatus = wakeStatus;

		// register writes
		if (selWrite) begin
			stateD.sel = regWdata[WER_SEL_W-1:0];
		end else if (irqWrite) begin
			stateD.irqEn = regWdata[WER_IRQ_LOW_N-1:0];
		end

		// register reads answer one cycle later; unmapped reads give zero
		if (regRead) begin
			stateD.rvalid = 1'b1;
			if (regAddr == WER_OFS_EVENT_SELECT) begin
				stateD.rdata = {{(WER_REG_W - WER_SEL_W){1'b0}}, stateQ.sel};
			end else if (regAddr == WER_OFS_STATE_ENABLE) begin
				stateD.rdata = {{(WER_REG_W - WER_CFG_W){1'b0}}, memBus.rdData};
			end else if (regAddr == WER_OFS_IRQ_EN_LOW) begin
				stateD.rdata = stateQ.irqEn;
			end else begin
				stateD.rdata = '0;
			end
		end

		// fixed-length pulse; a new trigger during a pulse is absorbed
		// so the button input on the far side sees one clean press
		if (stateQ.pulseCnt != '0) begin
			stateD.pulseCnt = stateQ.pulseCnt - CNT_ONE;
			stateD.pulseOut = (stateQ.pulseCnt != CNT_ONE);
		end else if (pulseTrigger) begin
			stateD.pulseCnt = PULSE_LOAD;
			stateD.pulseOut = 1'b1;
		end else begin
			stateD.pulseOut = 1'b0;
		end

		// power-on holds until the device has left both sleep states;
		// a trigger can only occur asleep so set never meets clear
		if (onTrigger) begin
			stateD.main_power_on_control = 1'b1;
		end else if (awake) begin
			stateD.main_power_on_control = 1'b0;
		end

		// registered or of all enabled low status bits
		stateD.irq = |irqHit;
	end

	// ==========================================================
	// state register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			stateQ       <= '0;
			stateQ.sel   <= WER_RST_EVENT_SELECT;
			stateQ.irqEn <= WER_RST_IRQ_EN_LOW;
		end else begin
			stateQ <= stateD;
		end
	end

	// ==========================================================
	// outputs come straight from the state register
	assign regRdata           = stateQ.rdata;
	assign regReadValid       = stateQ.rvalid;
	assign powerButtonOut     = stateQ.pulseOut;
	assign mainPowerOnControl = stateQ.main_power_on_control;
	assign irq                = stateQ.irq;

endmodule

// File: tb/wer_checker.sv
// assertion checker for the wake-up event routing block
`timescale 1ns/1ps
module wer_checker
	import wer_pkg::*;
#(
	parameter int unsigned PULSE_CYCLES = WER_PULSE_CYCLES
) (
	// clock and reset
	input wire logic                      core_clk,
	input wire logic                      reset,
	// register port
	input wire logic [WER_ADDR_W-1:0]     regAddr,
	input wire logic                      regWrite,
	input wire logic                      regRead,
	input wire logic [WER_REG_W-1:0]      regWdata,
	input wire logic [WER_REG_W-1:0]      regRdata,
	input wire logic                      regReadValid,
	// events, states and outputs
	input wire logic [WER_NUM_EVENTS-1:0] wakeStatus,
	input wire logic                      inSuspendRam,
	input wire logic                      inSoftOff,
	input wire logic                      buttonOutMode,
	input wire logic                      externalStateSelect,
	input wire logic                      powerButtonOut,
	input wire logic                      mainPowerOnControl,
	input wire logic                      irq
);
	logic [WER_NUM_EVENTS-1:0] prevQ;
	logic [WER_REG_W-1:0]      irqEnQ;
	int unsigned               pulseQ;
	logic                      riseAny;
	logic                      asleep;

	// ==========================================================
	// shadow state: last status, irq enable, pulse run length
	assign riseAny = |(wakeStatus & ~prevQ);
	assign asleep = inSuspendRam || inSoftOff;
	always_ff @(posedge core_clk) begin
		if (reset) begin
			prevQ <= '0;
			irqEnQ <= '0;
			pulseQ <= 0;
		end else begin
			prevQ <= wakeStatus;
			pulseQ <= powerButtonOut ? pulseQ + 1 : 0;
			if (regWrite && regAddr == WER_OFS_IRQ_EN_LOW) begin
				irqEnQ <= regWdata;
			end
		end
	end

	// ==========================================================
	// properties
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_irqen_read;
		regRead && regAddr == WER_OFS_IRQ_EN_LOW;
	endsequence

	a_irq_or_gate: assert property (!$past(reset) |->
		irq == |($past(wakeStatus[23:16]) & $past(irqEnQ))) else $error("irq mismatch");
	a_irqen_read: assert property (s_irqen_read |=> regRdata == $past(irqEnQ))
		else $error("irq enable readback");
	a_pulse_cause: assert property ($rose(powerButtonOut) |->
		$past(riseAny && asleep && !buttonOutMode)) else $error("pulse without cause");
	a_pulse_length: assert property (!$past(reset) && $fell(powerButtonOut) |->
		pulseQ == PULSE_CYCLES) else $error("pulse length");
	a_pulse_bound: assert property (pulseQ <= PULSE_CYCLES) else $error("pulse too long");
	a_power_cause: assert property ($rose(mainPowerOnControl) |->
		$past(riseAny && asleep && !externalStateSelect)) else $error("power without cause");
	a_power_hold: assert property (mainPowerOnControl && asleep |=> mainPowerOnControl)
		else $error("power dropped");
	a_power_clear: assert property (!asleep |=> !mainPowerOnControl)
		else $error("power not cleared");
	a_read_answer: assert property (regRead |=> regReadValid) else $error("no read valid");
	a_read_only: assert property (regReadValid |-> $past(regRead))
		else $error("stray read valid");
	a_unmapped_zero: assert property (regRead && regAddr > WER_OFS_IRQ_EN_LOW |=>
		regRdata == 8'h00) else $error("unmapped read not zero");
endmodule

bind wer_routing wer_checker #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.core_clk(core_clk),
	.reset(reset), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
	.regWdata(regWdata), .regRdata(regRdata), .regReadValid(regReadValid),
	.wakeStatus(wakeStatus), .inSuspendRam(inSuspendRam), .inSoftOff(inSoftOff),
	.buttonOutMode(buttonOutMode), .externalStateSelect(externalStateSelect),
	.powerButtonOut(powerButtonOut), .mainPowerOnControl(mainPowerOnControl), .irq(irq));

// File: tb/wer_platform_model.sv
// platform side model: watches the power-button line like a chipset would
`timescale 1ns/1ps
module wer_platform_model (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic reset,
	// lines from the routing block
	input  wire logic powerButtonOut,
	// what the platform saw
	output int        lastPulse,
	output int        pulseCount
);
	int runQ;

	// measure each pulse; a pulse is only counted once it has ended
	always_ff @(posedge core_clk) begin
		if (reset) begin
			runQ <= 0;
			lastPulse <= 0;
			pulseCount <= 0;
		end else if (powerButtonOut) begin
			runQ <= runQ + 1;
		end else if (runQ != 0) begin
			lastPulse <= runQ;
			pulseCount <= pulseCount + 1;
			runQ <= 0;
		end
	end
endmodule

// File: tb/tb_top.sv
// self-checking bench for the wake-up event routing block
`timescale 1ns/1ps
module tb_top
	import wer_pkg::*;
;
	localparam int unsigned PW = 4;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  regAddr = '0, regWdata = '0, regRdata, r;
	logic        regWrite = 1'b0, regRead = 1'b0, regReadValid;
	logic [31:0] wakeStatus = '0;
	logic        inSuspendRam = 1'b0, inSoftOff = 1'b0;
	logic        buttonOutMode = 1'b0, externalStateSelect = 1'b0;
	logic        powerButtonOut, mainPowerOnControl, irq;
	logic [3:0]  cfgs [32];
	logic [7:0]  expQ [$];
	int          lastPulse, pulseCount, pc, nMismatch = 0, checkCount = 0, seed = 32'h4e7e;

	always #10 core_clk = ~core_clk;

	wer_routing #(.PULSE_CYCLES(PW)) u_dut (.core_clk(core_clk), .reset(reset),
		.regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
		.regRdata(regRdata), .regReadValid(regReadValid), .wakeStatus(wakeStatus),
		.inSuspendRam(inSuspendRam), .inSoftOff(inSoftOff), .buttonOutMode(buttonOutMode),
		.externalStateSelect(externalStateSelect), .powerButtonOut(powerButtonOut),
		.mainPowerOnControl(mainPowerOnControl), .irq(irq));
	wer_platform_model u_plat (.core_clk(core_clk), .reset(reset),
		.powerButtonOut(powerButtonOut), .lastPulse(lastPulse), .pulseCount(pulseCount));

	// ==========================================================
	// shared tasks
	task automatic cyc(int n = 1);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
		checkCount++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, s);
			nMismatch++;
		end
	endtask
	// one idle edge after each strobe so a following call never
	// raises the strobe in the same time step that lowered it
	task automatic wr(logic [7:0] a, logic [7:0] d);
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		cyc();
		regWrite = 1'b0;
		cyc();
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		regAddr = a;
		regRead = 1'b1;
		expQ.push_back(e);
		cyc();
		regRead = 1'b0;
		cyc();
	endtask
	// one wake event with its expected pulse and power-on outcome
	task automatic wake(int ev, logic [3:0] cfg, logic sr, logic so, logic md, logic ex,
		logic p, logic o);
		wr(WER_OFS_EVENT_SELECT, 8'(ev));
		wr(WER_OFS_STATE_ENABLE, {4'ha, cfg});
		{inSuspendRam, inSoftOff, buttonOutMode, externalStateSelect} = {sr, so, md, ex};
		pc = pulseCount;
		wakeStatus[ev] = 1'b1;
		cyc(2);
		chk("powerButtonOut", 8'(p), 8'(powerButtonOut));
		chk("mainPowerOnControl", 8'(o), 8'(mainPowerOnControl));
		cyc(PW + 2);
		chk("pulseCount", 8'(pc + p), 8'(pulseCount));
		chk("mainPowerOnControl", 8'(o), 8'(mainPowerOnControl));
		if (p) chk("pulseLen", 8'(PW), 8'(lastPulse));
		{inSuspendRam, inSoftOff, buttonOutMode, externalStateSelect, wakeStatus} = '0;
		cyc(2);
		chk("mainPowerOnControl", 8'h00, 8'(mainPowerOnControl));
	endtask
	task automatic testDone();
		if (nMismatch == 0 && checkCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ==========================================================
	// read results are matched in order against the noted values
	always @(negedge core_clk) begin
		if (regReadValid === 1'b1) begin
			if (expQ.size() == 0) chk("regReadValid", 8'h00, 8'h01);
			else chk("regRdata", expQ.pop_front(), regRdata);
		end
	end

	// hang guard: the whole run is far shorter than this
	initial begin
		cyc(20000);
		nMismatch++;
		testDone();
	end

	initial begin
		cyc(2);
		reset = 1'b0;
		cyc();
		rd(WER_OFS_STATE_ENABLE, 8'h00);
		rd(WER_OFS_IRQ_EN_LOW, 8'h00);
		wr(8'h05, 8'hff);
		rd(8'h05, 8'h00);
		rd(WER_OFS_IRQ_EN_LOW, 8'h00);
		for (int i = 0; i < 32; i++) begin
			r = 8'($random(seed));
			cfgs[i] = WER_EVENTS_UNUSED[i] ? 4'h0 : r[3:0] & (WER_EVENTS_CLASS_B[i] ? 4'h3 : 4'hf);
			wr(WER_OFS_EVENT_SELECT, {r[7:5], 5'(i)});
			wr(WER_OFS_STATE_ENABLE, r);
			cyc();
			rd(WER_OFS_EVENT_SELECT, 8'(i));
		end
		// readback after all writes proves each event keeps its own entry
		for (int i = 0; i < 32; i++) begin
			wr(WER_OFS_EVENT_SELECT, 8'(i));
			cyc();
			rd(WER_OFS_STATE_ENABLE, {4'h0, cfgs[i]});
		end
		for (int n = 0; n < 8; n++) begin
			wr(WER_OFS_IRQ_EN_LOW, 8'h01 << n);
			wakeStatus[23:16] = 8'h01 << n;
			cyc(2);
			chk("irq", 8'h01, 8'(irq));
			wakeStatus[23:16] = ~(8'h01 << n);
			cyc(2);
			chk("irq", 8'h00, 8'(irq));
			r = 8'($random(seed));
			wr(WER_OFS_IRQ_EN_LOW, r);
			wakeStatus = $random(seed);
			cyc(2);
			chk("irq", 8'(|(wakeStatus[23:16] & r)), 8'(irq));
			rd(WER_OFS_IRQ_EN_LOW, r);
		end
		wakeStatus = '0;
		cyc(2);
		wake(3, 4'h8, 1, 0, 0, 0, 1, 0);
		wake(3, 4'h4, 0, 1, 0, 0, 1, 0);
		wake(3, 4'h4, 1, 0, 0, 0, 0, 0);
		wake(3, 4'hc, 0, 1, 1, 0, 0, 0);
		wake(5, 4'h2, 1, 0, 0, 0, 0, 1);
		wake(5, 4'h1, 0, 1, 0, 0, 0, 1);
		wake(5, 4'h3, 0, 1, 0, 1, 0, 0);
		wake(25, 4'hf, 0, 1, 0, 0, 0, 1);
		// a second reset in mid-run must clear enables that were set
		wr(WER_OFS_EVENT_SELECT, 8'h00);
		wr(WER_OFS_STATE_ENABLE, 8'hff);
		wr(WER_OFS_IRQ_EN_LOW, 8'hff);
		reset = 1'b1;
		cyc(2);
		reset = 1'b0;
		cyc();
		rd(WER_OFS_STATE_ENABLE, 8'h00);
		rd(WER_OFS_IRQ_EN_LOW, 8'h00);
		rd(WER_OFS_EVENT_SELECT, 8'h00);
		cyc(3);
		if (expQ.size() != 0) chk("pendingReads", 8'h00, 8'(expQ.size()));
		testDone();
	end
endmodule
